// [verilog/cawwd_pkg.sv]
// cawwd_pkg: constants and types for the counter array waveform/watchdog
// assumes an apb slave wrapper in cawwd_top and one system clock
package cawwd_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] CAWWD_OFF_CTRL   = 8'h00;
  localparam logic [7:0] CAWWD_OFF_MODE   = 8'h04;
  localparam logic [7:0] CAWWD_OFF_CNT_LO = 8'h08;
  localparam logic [7:0] CAWWD_OFF_CNT_HI = 8'h0C;
  localparam logic [7:0] CAWWD_OFF_UMODE  = 8'h10;
  localparam logic [7:0] CAWWD_OFF_CMP_LO = 8'h20;
  localparam logic [7:0] CAWWD_OFF_CMP_HI = 8'h30;
  localparam logic [7:0] CAWWD_OFF_STAT   = 8'h40;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CAWWD_CTRL_RUN   = 6;
  localparam int CAWWD_CTRL_CF    = 7;
  localparam int CAWWD_MODE_IDLE  = 7;
  localparam int CAWWD_MODE_WDE   = 6;
  localparam int CAWWD_MODE_LOCK  = 5;
  localparam int CAWWD_MODE_TBLSB = 1;
  localparam int CAWWD_UM_WIDE    = 7;
  localparam int CAWWD_UM_CMP     = 6;
  localparam int CAWWD_UM_MATCH   = 3;
  localparam int CAWWD_UM_TOG     = 2;
  localparam int CAWWD_UM_PWM     = 1;
  localparam int CAWWD_WD_UNIT    = 2;

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] CAWWD_MODE_RST  = 8'h40;
  localparam logic [7:0] CAWWD_UMODE_RST = 8'h00;
  localparam logic [7:0] CAWWD_BYTE_RST  = 8'h00;
  localparam logic [7:0] CAWWD_SWT_MODE  = 8'h48;
  localparam logic [3:0] CAWWD_DIV12     = 4'hC;
  localparam logic [3:0] CAWWD_DIV4      = 4'h4;
  localparam int         CAWWD_RST_CYC   = 4;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0]
  {
    CAWWD_M_OFF  = 3'b000,
    CAWWD_M_SWT  = 3'b001,
    CAWWD_M_FREQ = 3'b010,
    CAWWD_M_PWM8 = 3'b011,
    CAWWD_M_PW16 = 3'b100
  } cawwd_mode_e;

  typedef struct packed
  {
    logic        tick;
    logic [15:0] cnt;
    logic        lo_ovf;
    logic        full_ovf;
  } cawwd_time_s;

endpackage

// [verilog/cawwd_unit.sv]
// cawwd_unit: one capture/compare unit in its output-generating modes
// assumes the counter and tick come from cawwd_top in the same clock
`timescale 1ns/1ps
`default_nettype none
module cawwd_unit
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire cawwd_pkg::cawwd_time_s tm,
  input  wire logic [7:0]            mode,
  input  wire logic                  wr_lo,
  input  wire logic                  wr_hi,
  input  wire logic [7:0]            wdata,
  input  wire logic                  wd_on,
  input  wire logic                  flag_clr,
  output logic [7:0]                 cmp_lo,
  output logic [7:0]                 cmp_hi,
  output logic                       cmp_en,
  output logic                       flag,
  output logic                       match16,
  output logic                       pin
);
  import cawwd_pkg::*;

  cawwd_mode_e mode_sel;
  logic        lo_eq;
  logic        full_eq;
  logic        lo_nx_eq;
  logic        full_nx_eq;

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  always_comb
  begin
    mode_sel = CAWWD_M_OFF;
    if (wd_on)
      mode_sel = CAWWD_M_SWT;
    else if (mode[CAWWD_UM_PWM] && mode[CAWWD_UM_TOG])
      mode_sel = CAWWD_M_FREQ;
    else if (mode[CAWWD_UM_PWM] && !mode[CAWWD_UM_WIDE])
      mode_sel = CAWWD_M_PWM8;
    else if (mode[CAWWD_UM_PWM] && mode[CAWWD_UM_WIDE])
      mode_sel = CAWWD_M_PW16;
    else if (mode[CAWWD_UM_MATCH])
      mode_sel = CAWWD_M_SWT;
  end

  assign lo_eq   = tm.cnt[7:0] == cmp_lo;
  assign full_eq = tm.cnt == {cmp_hi, cmp_lo};
  assign match16 = full_eq;
  // pin is registered: raise it as the counter steps onto the compare value
  assign lo_nx_eq   = 8'(tm.cnt[7:0] + 8'h01) == cmp_lo;
  assign full_nx_eq = 16'(tm.cnt + 16'h0001) == {cmp_hi, cmp_lo};

  // ---------------------------------------------------------------
  // compare enable, set by high byte write, cleared by low byte write
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmp_en <= 1'b0;
    else if (wr_hi)
      cmp_en <= 1'b1;
    else if (wr_lo)
      cmp_en <= 1'b0;
    else if (mode_sel == CAWWD_M_OFF && 1'b0)
      cmp_en <= 1'b0;
  end

  // ---------------------------------------------------------------
  // compare low byte
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmp_lo <= CAWWD_BYTE_RST;
    else if (wr_lo)
      cmp_lo <= wdata;
    else if (tm.tick && cmp_en && mode_sel == CAWWD_M_FREQ && lo_eq)
      cmp_lo <= 8'(cmp_lo + cmp_hi);
    else if (tm.tick && cmp_en && mode_sel == CAWWD_M_PWM8 && tm.lo_ovf)
      cmp_lo <= cmp_hi;
  end

  // ---------------------------------------------------------------
  // compare high byte; watchdog update loads counter high plus offset
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmp_hi <= CAWWD_BYTE_RST;
    else if (wr_hi && wd_on)
      cmp_hi <= 8'(tm.cnt[15:8] + cmp_lo);
    else if (wr_hi)
      cmp_hi <= wdata;
  end

  // ---------------------------------------------------------------
  // event flag: hardware set wins over software clear
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag <= 1'b0;
    else if (tm.tick && cmp_en && full_eq &&
             (mode[CAWWD_UM_MATCH] || mode_sel == CAWWD_M_SWT))
      flag <= 1'b1;
    else if (flag_clr)
      flag <= 1'b0;
  end

  // ---------------------------------------------------------------
  // output pin
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin <= 1'b0;
    else
      case (mode_sel)
        CAWWD_M_FREQ:
        begin
          if (tm.tick && cmp_en && lo_eq)
            pin <= ~pin;
        end
        CAWWD_M_PWM8:
        begin
          if (!cmp_en)
            pin <= 1'b0;
          else if (tm.tick && tm.lo_ovf)
            pin <= (cmp_hi == 8'h00);
          else if (tm.tick && lo_nx_eq)
            pin <= 1'b1;
        end
        CAWWD_M_PW16:
        begin
          if (!cmp_en)
            pin <= 1'b0;
          else if (tm.tick && tm.full_ovf)
            pin <= ({cmp_hi, cmp_lo} == 16'h0000);
          else if (tm.tick && full_nx_eq)
            pin <= 1'b1;
        end
        default:
          pin <= pin;
      endcase
  end

endmodule
`default_nettype wire

// [verilog/cawwd_top.sv]
// cawwd_top: counter array with waveform units and unit-two watchdog
// assumes an apb master on pclk, timer0 overflow and eci given synchronous
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module cawwd_top
#(
  parameter int NUM_UNITS = 3
)
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 cpu_idle,
  input  wire logic                 timer0_ovf,
  input  wire logic                 eci_in,
  input  wire logic                 ext_div8_tick,
  output logic [NUM_UNITS-1:0]      unit_output_pin,
  output logic                      watchdog_reset
);
  import cawwd_pkg::*;

  logic                 wr_en;
  logic                 rd_en;
  logic [7:0]           wb;
  logic                 counter_run_r;
  logic                 ovf_flag_r;
  logic [7:0]           mode_r;
  logic [7:0]           umode_r [NUM_UNITS];
  logic [15:0]          cnt_r;
  logic [3:0]           pre_r;
  logic                 eci_d_r;
  logic [7:0]           snap_r;
  logic                 wd_on;
  logic                 running;
  logic                 tick;
  cawwd_time_s          tm;
  logic [NUM_UNITS-1:0] wr_lo;
  logic [NUM_UNITS-1:0] wr_hi;
  logic [NUM_UNITS-1:0] flag_clr;
  logic [NUM_UNITS-1:0] cmp_en;
  logic [NUM_UNITS-1:0] flag;
  logic [NUM_UNITS-1:0] m16;
  logic [7:0]           cmp_lo [NUM_UNITS];
  logic [7:0]           cmp_hi [NUM_UNITS];
  logic [7:0]           umode_eff [NUM_UNITS];
  logic                 force_rst;
  logic [2:0]           rst_cnt_r;

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] o);
    is_reg = (a == o);
  endfunction

  // ---------------------------------------------------------------
  // apb slave: zero wait states, unmapped reads zero
  // ---------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign wb      = pwdata[7:0];

  assign wd_on = mode_r[CAWWD_MODE_WDE] || mode_r[CAWWD_MODE_LOCK];
  assign running = (counter_run_r || wd_on) &&
                   !(mode_r[CAWWD_MODE_IDLE] && cpu_idle);

  // ---------------------------------------------------------------
  // control: run bit and overflow flag
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      counter_run_r <= 1'b0;
    else if (wr_en && is_reg(paddr, CAWWD_OFF_CTRL))
      counter_run_r <= wb[CAWWD_CTRL_RUN];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ovf_flag_r <= 1'b0;
    else if (tm.tick && tm.full_ovf)
      ovf_flag_r <= 1'b1;
    else if (wr_en && is_reg(paddr, CAWWD_OFF_CTRL) && !wb[CAWWD_CTRL_CF])
      ovf_flag_r <= 1'b0;
  end

  // ---------------------------------------------------------------
  // array mode: only WDE writable while watchdog on and unlocked, lock sticky until reset
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_r <= CAWWD_MODE_RST;
    else if (wr_en && is_reg(paddr, CAWWD_OFF_MODE))
    begin
      if (!wd_on)
        mode_r <= {wb[7:5], 1'b0, wb[3:0]};
      else if (!mode_r[CAWWD_MODE_LOCK])
        mode_r[CAWWD_MODE_WDE] <= wb[CAWWD_MODE_WDE];
      else
        mode_r <= mode_r;
    end
  end

  // ---------------------------------------------------------------
  // unit mode registers; unit two locked under watchdog
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int i = 0; i < NUM_UNITS; i++)
        umode_r[i] <= CAWWD_UMODE_RST;
    else
      for (int i = 0; i < NUM_UNITS; i++)
        if (wr_en && is_reg(paddr, 8'(CAWWD_OFF_UMODE + 4 * i)) &&
            !(wd_on && i == CAWWD_WD_UNIT))
          umode_r[i] <= wb;
  end

  always_comb
  begin
    for (int i = 0; i < NUM_UNITS; i++)
      umode_eff[i] = (wd_on && i == CAWWD_WD_UNIT) ? CAWWD_SWT_MODE
                                                   : umode_r[i];
  end

  // ---------------------------------------------------------------
  // timebase tick selection
  // ---------------------------------------------------------------
  always_comb
  begin
    case (mode_r[CAWWD_MODE_TBLSB +: 3])
      3'b000:  tick = (pre_r == 4'(CAWWD_DIV12 - 1));
      3'b001:  tick = (pre_r[1:0] == 2'(CAWWD_DIV4 - 1));
      3'b010:  tick = timer0_ovf;
      3'b011:  tick = eci_d_r && !eci_in;
      3'b100:  tick = 1'b1;
      3'b101:  tick = ext_div8_tick;
      default: tick = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_r <= 4'h0;
    else if (!running || tick)
      pre_r <= 4'h0;
    else
      pre_r <= 4'(pre_r + 4'h1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      eci_d_r <= 1'b1;
    else
      eci_d_r <= eci_in;
  end

  // ---------------------------------------------------------------
  // 16-bit counter; software writes ignored under watchdog
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= 16'h0000;
    else if (wr_en && !wd_on && is_reg(paddr, CAWWD_OFF_CNT_LO))
      cnt_r[7:0] <= wb;
    else if (wr_en && !wd_on && is_reg(paddr, CAWWD_OFF_CNT_HI))
      cnt_r[15:8] <= wb;
    else if (running && tick)
      cnt_r <= 16'(cnt_r + 16'h0001);
  end

  assign tm.tick     = running && tick;
  assign tm.cnt      = cnt_r;
  assign tm.lo_ovf   = cnt_r[7:0] == 8'hFF;
  assign tm.full_ovf = cnt_r == 16'hFFFF;

  // ---------------------------------------------------------------
  // capture/compare units
  // ---------------------------------------------------------------
  generate
    for (genvar g = 0; g < NUM_UNITS; g++)
    begin : g_unit
      assign wr_lo[g] = wr_en && is_reg(paddr, 8'(CAWWD_OFF_CMP_LO + 4 * g));
      assign wr_hi[g] = wr_en && is_reg(paddr, 8'(CAWWD_OFF_CMP_HI + 4 * g));
      assign flag_clr[g] = wr_en && is_reg(paddr, CAWWD_OFF_CTRL) && !wb[g];
      cawwd_unit u_unit
      (
        .pclk     (pclk),
        .presetn  (presetn),
        .tm       (tm),
        .mode     (umode_eff[g]),
        .wr_lo    (wr_lo[g]),
        .wr_hi    (wr_hi[g]),
        .wdata    (wb),
        .wd_on    (wd_on && g == CAWWD_WD_UNIT),
        .flag_clr (flag_clr[g]),
        .cmp_lo   (cmp_lo[g]),
        .cmp_hi   (cmp_hi[g]),
        .cmp_en   (cmp_en[g]),
        .flag     (flag[g]),
        .match16  (m16[g]),
        .pin      (unit_output_pin[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // watchdog reset generation, held for a fixed pulse
  // ---------------------------------------------------------------
  assign force_rst = wd_on && ((tm.tick && tm.lo_ovf &&
                     cmp_hi[CAWWD_WD_UNIT] == cnt_r[15:8]) ||
                     (wr_en && is_reg(paddr, CAWWD_OFF_CTRL) &&
                      wb[CAWWD_WD_UNIT]));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rst_cnt_r <= 3'h0;
    else if (force_rst)
      rst_cnt_r <= 3'(CAWWD_RST_CYC);
    else if (rst_cnt_r != 3'h0)
      rst_cnt_r <= 3'(rst_cnt_r - 3'h1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      watchdog_reset <= 1'b0;
    else
      watchdog_reset <= force_rst || (rst_cnt_r > 3'h1);
  end

  // ---------------------------------------------------------------
  // read data and counter high snapshot
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      snap_r <= 8'h00;
    else if (rd_en && is_reg(paddr, CAWWD_OFF_CNT_LO))
      snap_r <= cnt_r[15:8];
  end

  always_comb
  begin
    prdata = 32'h0000_0000;
    if (is_reg(paddr, CAWWD_OFF_CTRL))
      prdata[7:0] = {ovf_flag_r, counter_run_r, 3'b000,
                     3'(flag)};
    else if (is_reg(paddr, CAWWD_OFF_MODE))
      prdata[7:0] = mode_r;
    else if (is_reg(paddr, CAWWD_OFF_CNT_LO))
      prdata[7:0] = cnt_r[7:0];
    else if (is_reg(paddr, CAWWD_OFF_CNT_HI))
      prdata[7:0] = snap_r;
    else if (is_reg(paddr, CAWWD_OFF_STAT))
      prdata[7:0] = {2'b00, 3'(m16), 3'(cmp_en)};
    else
      for (int i = 0; i < NUM_UNITS; i++)
      begin
        if (is_reg(paddr, 8'(CAWWD_OFF_UMODE + 4 * i)))
          prdata[7:0] = (umode_r[i] & 8'hBF) | {1'b0, cmp_en[i], 6'h00};
        if (is_reg(paddr, 8'(CAWWD_OFF_CMP_LO + 4 * i)))
          prdata[7:0] = cmp_lo[i];
        if (is_reg(paddr, 8'(CAWWD_OFF_CMP_HI + 4 * i)))
          prdata[7:0] = cmp_hi[i];
      end
  end

endmodule
`default_nettype wire

// [test/cawwd_pin_meter.sv]
// cawwd_pin_meter: load on the unit output pins, counts high cycles and edges
// assumes pins sampled on pclk; clr restarts both counts
`timescale 1ns/1ps
`default_nettype none
module cawwd_pin_meter
(
  input  wire logic        pclk,
  input  wire logic [2:0]  pins,
  input  wire logic [1:0]  sel,
  input  wire logic        clr,
  output logic [15:0]      hi_cnt,
  output logic [15:0]      edg_cnt
);
  logic prev_r;

  always_ff @(posedge pclk)
  begin
    if (clr)
      {hi_cnt, edg_cnt} <= 32'h0;
    else
      {hi_cnt, edg_cnt} <= {hi_cnt + 16'(pins[sel]),
                            edg_cnt + 16'(pins[sel] != prev_r)};
    prev_r <= pins[sel];
  end
endmodule
`default_nettype wire

// [test/cawwd_asserts.sv]
// cawwd_asserts: port-level properties of cawwd_top
// assumes one clock pclk and async active-low presetn
`timescale 1ns/1ps
`default_nettype none
module cawwd_asserts
#(
  parameter int NUM_UNITS = 3
)
(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [NUM_UNITS-1:0] unit_output_pin,
  input wire logic                 watchdog_reset
);
  import cawwd_pkg::*;
  logic       wr;
  logic       rd;
  logic       on;
  logic       wde_r;
  logic       lock_r;
  logic       idle_r;
  logic       run_r;
  logic [2:0] tb_r;
  logic [3:0] off_r;

  // ---------------------------------------------------------------
  // shadow of the mode and run bits
  // ---------------------------------------------------------------
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign on = wde_r | lock_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {wde_r, lock_r, idle_r, tb_r} <= 6'h20;
    else if (wr && paddr == CAWWD_OFF_MODE)
    begin
      if (!on)
        {idle_r, lock_r, tb_r} <= {pwdata[7], pwdata[5], pwdata[3:1]};
      if (!lock_r)
        wde_r <= pwdata[6];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      run_r <= 1'b0;
    else if (wr && paddr == CAWWD_OFF_CTRL)
      run_r <= pwdata[CAWWD_CTRL_RUN];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      off_r <= 4'h0;
    else
      off_r <= on ? 4'h0 : off_r + 4'(off_r != 4'hF);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_high: assert property (pready)
    else $error("pready low");
  a_no_error: assert property (!pslverr)
    else $error("pslverr set");
  a_upper_zero: assert property (rd |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_mode_read: assert property (rd && paddr == CAWWD_OFF_MODE
    |-> prdata[7:1] == {idle_r, wde_r, lock_r, 1'b0, tb_r})
    else $error("mode register read wrong");
  a_run_read: assert property (rd && paddr == CAWWD_OFF_CTRL
    |-> prdata[6] == run_r && prdata[5:3] == 3'h0)
    else $error("run bit read wrong");
  a_force_reset: assert property (wr && paddr == CAWWD_OFF_CTRL
    && pwdata[2] && on |-> ##[1:3] watchdog_reset)
    else $error("forced watchdog reset missing");
  a_reset_pulse: assert property ($rose(watchdog_reset)
    |-> watchdog_reset[*3])
    else $error("watchdog reset pulse too short");
  a_wd_quiet: assert property (off_r == 4'hF |-> !watchdog_reset)
    else $error("watchdog reset while disabled");

  c_lock: cover property (wr && paddr == CAWWD_OFF_MODE && pwdata[5]);
  c_wd_fire: cover property ($rose(watchdog_reset));
  c_pin_rise: cover property ($rose(unit_output_pin[0]));
endmodule

bind cawwd_top cawwd_asserts #(.NUM_UNITS(NUM_UNITS)) u_chk
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .unit_output_pin, .watchdog_reset
);
`default_nettype wire

// [test/counter_array_waveform_watchdog_bench.sv]
// counter_array_waveform_watchdog_bench: self-checking bench for cawwd_top
// assumes cawwd_asserts bound to the top and the pin meter as the load
`timescale 1ns/1ps
`default_nettype none
module counter_array_waveform_watchdog_bench;
  import cawwd_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  pins;
  logic        wdr;
  logic        mclr = 1'b0;
  logic [1:0]  msel = 2'h0;
  logic [15:0] hi_c;
  logic [15:0] ed_c;
  logic [31:0] seed = 32'h16084;
  logic [31:0] rd;
  logic [31:0] rnd;
  logic [7:0]  h;
  int          lo;
  int          n_errors = 0;
  int          checked = 0;

  cawwd_top #(.NUM_UNITS(3)) dut
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cpu_idle(1'b0), .timer0_ovf(1'b0), .eci_in(1'b1),
    .ext_div8_tick(1'b0), .unit_output_pin(pins), .watchdog_reset(wdr)
  );
  cawwd_pin_meter meter
  (
    .pclk, .pins, .sel(msel), .clr(mclr), .hi_cnt(hi_c), .edg_cnt(ed_c)
  );

  initial
    forever #4 pclk = ~pclk;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] duty8(input logic [7:0] v);
    return 16'h200 - {7'h0, v, 1'b0};
  endfunction

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20)
    begin
      n_errors++;
      finish_test();
    end
    @(posedge pclk);
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic r(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  task automatic wait_wd(input int lo_b, input int hi_b);
    int n;
    n = 0;
    while (wdr !== 1'b1 && n < hi_b)
    begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, wdr === 1'b1 && n >= lo_b}, 32'h1);
    do_reset();
  endtask

  task automatic meas(input logic [1:0] u, input int n,
                      input logic [15:0] eh, input logic [15:0] ee);
    msel <= u;
    mclr <= 1'b1;
    @(posedge pclk);
    mclr <= 1'b0;
    repeat (n) @(posedge pclk);
    #1;
    chk({16'h0, hi_c}, {16'h0, eh});
    chk({16'h0, ed_c}, {16'h0, ee});
    @(posedge pclk);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial
  begin
    do_reset();
    wait_wd(3060, 3090);
    r(CAWWD_OFF_MODE, 8'h40);
    r(CAWWD_OFF_CTRL, 8'h00);
    r(8'h28, 8'h00);
    w(CAWWD_OFF_CNT_HI, 8'h55);
    apb(1'b0, CAWWD_OFF_CNT_LO, 8'h00);
    r(CAWWD_OFF_CNT_HI, 8'h00);
    w(CAWWD_OFF_CTRL, 8'h04);
    wait_wd(0, 4);
    $display("test default timeout and force done");
    w(8'h28, 8'h01);
    apb(1'b0, CAWWD_OFF_CNT_LO, 8'h00);
    lo = int'(rd[7:0]);
    w(8'h38, 8'h00);
    r(8'h38, 8'h01);
    wait_wd((512 - lo) * 12 - 40, (512 - lo) * 12 + 20);
    w(CAWWD_OFF_MODE, 8'h00);
    r(CAWWD_OFF_MODE, 8'h00);
    w(CAWWD_OFF_MODE, 8'h40);
    w(CAWWD_OFF_MODE, 8'h42);
    r(CAWWD_OFF_MODE, 8'h40);
    w(CAWWD_OFF_MODE, 8'h00);
    w(CAWWD_OFF_MODE, 8'h20);
    w(CAWWD_OFF_MODE, 8'h00);
    r(CAWWD_OFF_MODE, 8'h20);
    w(CAWWD_OFF_CTRL, 8'h04);
    wait_wd(0, 4);
    $display("test update, enable and lock done");
    w(CAWWD_OFF_MODE, 8'h00);
    w(CAWWD_OFF_MODE, 8'h08);
    w(CAWWD_OFF_CNT_LO, 8'h00);
    w(CAWWD_OFF_CNT_HI, 8'hFF);
    apb(1'b0, CAWWD_OFF_CNT_LO, 8'h00);
    r(CAWWD_OFF_CNT_HI, 8'hFF);
    w(8'h18, 8'hC2);
    w(8'h28, 8'hF0);
    w(8'h38, 8'hFF);
    w(CAWWD_OFF_CTRL, 8'h40);
    meas(2'h2, 300, 16'h10, 16'h2);
    $display("test wide pwm done");
    for (int k = 0; k < 4; k++)
    begin
      rnd = xs();
      h = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : rnd[7:0];
      lo = (h == 8'h00) ? 0 : 4;
      w(8'h10, 8'h42);
      w(8'h20, h);
      w(8'h30, h);
      repeat (300) @(posedge pclk);
      meas(2'h0, 512, duty8(h), 16'(lo));
    end
    w(8'h20, 8'h10);
    r(8'h10, 8'h02);
    repeat (300) @(posedge pclk);
    meas(2'h0, 512, 16'h0, 16'h0);
    w(8'h30, 8'h80);
    r(8'h10, 8'h42);
    $display("test byte pwm done");
    for (int k = 0; k < 2; k++)
    begin
      rnd = xs();
      h = 8'(rnd % 255) + 8'h01;
      w(8'h14, 8'h46);
      w(8'h24, 8'h00);
      w(8'h34, h);
      repeat (600) @(posedge pclk);
      meas(2'h1, 8 * int'(h), {6'h0, h, 2'h0}, 16'h8);
    end
    $display("test frequency output done");
    finish_test();
  end
endmodule
`default_nettype wire
